/* File: tx1010_line_encoder.sv */
`timescale 1ns/1ns
module tx1010_line_encoder import tx1010_pkg::*; #(
  parameter int NLP_PERIOD = NLP_PERIOD_CYC,
  parameter int JABBER_LIM = JABBER_CYC,
  parameter int UNJAB_LIM  = UNJAB_CYC
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       nibble_tx_clock,
  input  wire logic       transmit_gate,
  input  wire logic       txErr,
  input  wire logic [3:0] txNibble,
  input  wire logic       speed100,
  input  wire logic [4:0] station_address_strap,
  output logic            mltPlus,
  output logic            mltMinus,
  output logic            tenLevel,
  output logic            tenDriveEn,
  output logic            jabberStatus
);
  localparam int NW = $clog2(NLP_PERIOD + 1);
  localparam int JW = $clog2(JABBER_LIM + 1);
  localparam int UW = $clog2(UNJAB_LIM + 1);

  if (NLP_PERIOD <= NLP_WIDTH_CYC || JABBER_LIM < 2 || UNJAB_LIM < 2) begin : g_chk
    $error("tx1010_line_encoder: timing parameters too small");
  end

  //////////////////////////////////////////////////////////////////////////////
  // link side: answer each request with a fresh sample of the MAC pins
  logic           reqSyncA_r, reqSyncB_r, ackTog_r, reqTog_r;
  tx1010_sample_t hold_r;

  always_ff @(posedge nibble_tx_clock or negedge rst_n) begin
    if (!rst_n) begin
      reqSyncA_r <= 1'b0;
      reqSyncB_r <= 1'b0;
    end else begin
      reqSyncA_r <= reqTog_r;
      reqSyncB_r <= reqSyncA_r;
    end
  end

  // pins are valid at this edge by the MAC's own timing
  always_ff @(posedge nibble_tx_clock or negedge rst_n) begin
    if (!rst_n) begin
      hold_r   <= '0;
      ackTog_r <= 1'b0;
    end else if (reqSyncB_r != ackTog_r) begin
      hold_r   <= '{gate: transmit_gate, err: txErr, nib: txNibble};
      ackTog_r <= reqSyncB_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system side: pin synchronisers and sample pickup
  logic           ackSyncA_r, ackSyncB_r;
  logic           spdA_r, spdB_r;
  logic [4:0]     addrA_r, addrB_r;
  tx1010_sample_t smp_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ackSyncA_r <= 1'b0;
      ackSyncB_r <= 1'b0;
      spdA_r     <= 1'b0;
      spdB_r     <= 1'b0;
      addrA_r    <= 5'h00;
      addrB_r    <= 5'h00;
    end else begin
      ackSyncA_r <= ackTog_r;
      ackSyncB_r <= ackSyncA_r;
      spdA_r     <= speed100;
      spdB_r     <= spdA_r;
      addrA_r    <= station_address_strap;
      addrB_r    <= addrA_r;
    end
  end

  // hold_r is stable once the ack is seen, so it is read only then
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      smp_r    <= '0;
      reqTog_r <= 1'b0;
    end else if (ackSyncB_r == reqTog_r) begin
      smp_r    <= hold_r;
      reqTog_r <= ~reqTog_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // tick counter: 5 bits per code-group, 8 half-bits per 10M nibble
  logic [2:0] tick_r;
  logic       lastTick;

  assign lastTick = spdB_r ? (tick_r == 3'(SYM_BITS - 1)) : (tick_r == 3'(TEN_NIB_TICKS - 1));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 3'h0;
    end else begin
      tick_r <= lastTick ? 3'h0 : tick_r + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 100M code-group selection
  tx1010_fx_t fx_r, fx_nxt;
  logic [4:0] cg_nxt, cg_r;

  always_comb begin
    fx_nxt = fx_r;
    cg_nxt = CG_IDLE;
    case (fx_r)
      FX_IDLE: begin
        if (smp_r.gate) begin
          fx_nxt = FX_J;
          cg_nxt = CG_J;
        end else begin
          cg_nxt = CG_IDLE;
        end
      end
      FX_J: begin
        fx_nxt = FX_K;
        cg_nxt = CG_K;
      end
      FX_K, FX_DATA: begin
        if (smp_r.gate) begin
          fx_nxt = FX_DATA;
          cg_nxt = smp_r.err ? CG_HALT : tx1010_enc(smp_r.nib);
        end else begin
          fx_nxt = FX_T;
          cg_nxt = CG_T;
        end
      end
      FX_T: begin
        fx_nxt = FX_R;
        cg_nxt = CG_R;
      end
      FX_R: begin
        fx_nxt = FX_IDLE;
        cg_nxt = CG_IDLE;
      end
      default: begin
        fx_nxt = FX_IDLE;
        cg_nxt = CG_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fx_r <= FX_IDLE;
      cg_r <= CG_IDLE;
    end else if (!spdB_r) begin
      fx_r <= FX_IDLE;
      cg_r <= CG_IDLE;
    end else if (lastTick) begin
      fx_r <= fx_nxt;
      cg_r <= cg_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // serializer, scrambler, NRZI and three-level split
  // line bit rate equals clk_sys here; a real line runs the same logic at 125 MHz
  logic        serBit, scrFb, scrBit;
  logic [1:0]  seedWait_r;
  logic [10:0] scr_r;
  logic        nrzi_r;
  logic        mltNeg_r;

  assign serBit = cg_r[3'(SYM_BITS - 1) - tick_r];
  assign scrFb  = scr_r[10] ^ scr_r[8];
  assign scrBit = serBit ^ scrFb;

  // strap is loaded on the third edge after reset, once both synchroniser stages hold it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scr_r      <= SCR_RESET;
      seedWait_r <= 2'h0;
    end else if (seedWait_r == 2'h2) begin
      scr_r      <= {SEED_FILL, addrB_r};
      seedWait_r <= 2'h3;
    end else begin
      scr_r      <= {scr_r[9:0], scrFb};
      if (seedWait_r != 2'h3) begin
        seedWait_r <= seedWait_r + 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nrzi_r <= 1'b0;
    end else if (scrBit && spdB_r) begin
      nrzi_r <= ~nrzi_r;
    end
  end

  // sign flips each time NRZI returns to zero, so ones alternate between the streams
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mltNeg_r <= 1'b0;
    end else if (scrBit && spdB_r && nrzi_r) begin
      mltNeg_r <= ~mltNeg_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // 10M Manchester encoder
  tx1010_ten_t ten_r;
  logic [3:0]  tenNib_r;
  logic        tenBit, tenCell, gated, nlpOn;

  assign tenBit  = tenNib_r[tick_r[2:1]];
  // one: low then high; zero: high then low
  assign tenCell = tick_r[0] ? tenBit : ~tenBit;
  assign gated   = !spdB_r && smp_r.gate;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ten_r    <= TEN_OFF;
      tenNib_r <= 4'h0;
    end else if (spdB_r) begin
      ten_r    <= TEN_OFF;
    end else begin
      case (ten_r)
        TEN_OFF: begin
          // a frame waits out a link pulse so the two never merge on the line
          if (lastTick && gated && !nlpOn) begin
            ten_r    <= TEN_RUN;
            tenNib_r <= smp_r.nib;
          end
        end
        TEN_RUN: begin
          if (lastTick) begin
            if (gated) begin
              tenNib_r <= smp_r.nib;
            end else begin
              ten_r <= TEN_TAIL;
            end
          end
        end
        TEN_TAIL: ten_r <= TEN_OFF;
        default:  ten_r <= TEN_OFF;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // idle link pulse timer
  logic [NW-1:0] nlpCnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      nlpCnt_r <= '0;
    end else if (spdB_r || ten_r != TEN_OFF) begin
      nlpCnt_r <= '0;
    end else begin
      nlpCnt_r <= (nlpCnt_r == NW'(NLP_PERIOD - 1)) ? '0 : nlpCnt_r + 1'b1;
    end
  end

  // pulse sits at the end of the period, so reset or a frame never triggers one at once
  assign nlpOn = !spdB_r && ten_r == TEN_OFF
                 && nlpCnt_r >= NW'(NLP_PERIOD - NLP_WIDTH_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // jabber guard
  logic [JW-1:0] jabCnt_r;
  logic [UW-1:0] unjabCnt_r;
  logic          jab_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      jabCnt_r   <= '0;
      unjabCnt_r <= '0;
      jab_r      <= 1'b0;
    end else if (spdB_r) begin
      jabCnt_r   <= '0;
      unjabCnt_r <= '0;
      jab_r      <= 1'b0;
    end else if (!jab_r) begin
      unjabCnt_r <= '0;
      if (!gated) begin
        jabCnt_r <= '0;
      end else if (jabCnt_r == JW'(JABBER_LIM)) begin
        jab_r    <= 1'b1;
      end else begin
        jabCnt_r <= jabCnt_r + 1'b1;
      end
    end else if (gated) begin
      unjabCnt_r <= '0;
    end else if (unjabCnt_r == UW'(UNJAB_LIM - 1)) begin
      jab_r      <= 1'b0;
      jabCnt_r   <= '0;
    end else begin
      unjabCnt_r <= unjabCnt_r + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mltPlus      <= 1'b0;
      mltMinus     <= 1'b0;
      tenLevel     <= 1'b0;
      tenDriveEn   <= 1'b0;
      jabberStatus <= 1'b0;
    end else begin
      mltPlus      <= spdB_r && nrzi_r && !mltNeg_r;
      mltMinus     <= spdB_r && nrzi_r && mltNeg_r;
      // tail drives high: a trailing zero gets its rising end-of-cell edge
      tenLevel     <= (ten_r == TEN_RUN) ? tenCell : (ten_r == TEN_TAIL || nlpOn);
      tenDriveEn   <= !spdB_r && !jab_r && (ten_r != TEN_OFF || nlpOn);
      jabberStatus <= !spdB_r && jab_r;
    end
  end
endmodule

/* File: tx1010_pkg.sv */
package tx1010_pkg;
  localparam int CLK_HZ          = 20_000_000;
  localparam int NLP_WIDTH_NS    = 100;
  localparam int NLP_PERIOD_MS   = 16;
  localparam int JABBER_MS       = 25;
  localparam int UNJAB_MS        = 500;
  localparam int NLP_WIDTH_CYC   = (NLP_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int NLP_PERIOD_CYC  = NLP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int JABBER_CYC      = JABBER_MS * (CLK_HZ / 1000);
  localparam int UNJAB_CYC       = UNJAB_MS * (CLK_HZ / 1000);
  localparam int SYM_BITS        = 5;
  localparam int TEN_NIB_TICKS   = 8;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J    = 5'h18;
  localparam logic [4:0] CG_K    = 5'h11;
  localparam logic [4:0] CG_T    = 5'h0D;
  localparam logic [4:0] CG_R    = 5'h07;
  localparam logic [4:0] CG_HALT = 5'h04;
  localparam logic [5:0] SEED_FILL = 6'h2B;
  localparam logic [10:0] SCR_RESET = 11'h7FF;

  typedef struct packed {
    logic       gate;
    logic       err;
    logic [3:0] nib;
  } tx1010_sample_t;

  typedef enum logic [2:0] {
    FX_IDLE, FX_J, FX_K, FX_DATA, FX_T, FX_R
  } tx1010_fx_t;

  typedef enum logic [1:0] {
    TEN_OFF, TEN_RUN, TEN_TAIL
  } tx1010_ten_t;

  function automatic logic [4:0] tx1010_enc(input logic [3:0] n);
    logic [4:0] c;
    c = CG_IDLE;
    case (n)
      4'h0: c = 5'h1E;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0A;
      4'h5: c = 5'h0B;
      4'h6: c = 5'h0E;
      4'h7: c = 5'h0F;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'hA: c = 5'h16;
      4'hB: c = 5'h17;
      4'hC: c = 5'h1A;
      4'hD: c = 5'h1B;
      4'hE: c = 5'h1C;
      default: c = 5'h1D;
    endcase
    return c;
  endfunction
endpackage

/* File: tx1010_assertions.sv */
`timescale 1ns/1ns
module tx1010_assertions #(
  parameter int JABBER_LIM = 400,
  parameter int UNJAB_LIM  = 300
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic transmit_gate,
  input wire logic speed100,
  input wire logic mltPlus,
  input wire logic mltMinus,
  input wire logic tenLevel,
  input wire logic tenDriveEn,
  input wire logic jabberStatus
);
  int hi;
  int lo;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // raw gate run lengths; the design sees the gate later, so its counts trail these
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi <= 0;
      lo <= 0;
    end else begin
      hi <= transmit_gate ? hi + 1 : 0;
      lo <= transmit_gate ? 0 : lo + 1;
    end
  end
  ////////////////////
  mlt_step_a: assert property (mltPlus |=> !mltMinus)
    else $error("mlt skipped zero");
  mlt_quiet_a: assert property (!speed100 [*5] |-> !mltPlus && !mltMinus)
    else $error("mlt active at 10M");
  jab_zero_a: assert property (speed100 [*5] |-> !jabberStatus)
    else $error("jabber at 100M");
  jab_cut_a: assert property (jabberStatus |-> !tenDriveEn)
    else $error("drive during jabber");
  jab_set_a: assert property (!speed100 && hi > JABBER_LIM + 40 |-> jabberStatus)
    else $error("jabber missed");
  jab_min_a: assert property ($rose(jabberStatus) |-> hi >= JABBER_LIM)
    else $error("jabber early");
  unjab_min_a:
    assert property ($fell(jabberStatus) && !speed100 |-> lo >= UNJAB_LIM)
    else $error("unjab early");
  unjab_max_a: assert property (lo > UNJAB_LIM + 40 |-> !jabberStatus)
    else $error("unjab late");
  ten_run_a:
    assert property ((tenLevel && tenDriveEn) [*2] |=> !(tenLevel && tenDriveEn))
    else $error("line high too long");
  last_edge_a:
    assert property ($fell(tenDriveEn) && !jabberStatus |=> jabberStatus || $past(tenLevel, 2))
    else $error("last transition not positive");
endmodule

bind tx1010_line_encoder tx1010_assertions #(
  .JABBER_LIM(JABBER_LIM), .UNJAB_LIM(UNJAB_LIM)) u_chk (.*);

/* File: tx1010_mac_model.sv */
`timescale 1ns/1ns
module tx1010_mac_model import tx1010_pkg::*; (
  input  wire logic          nibble_tx_clock,
  output var tx1010_sample_t smp
);
  initial smp = '0;
  // a nibble stands 16 link clocks, about two code-groups, so the sampler cannot miss it;
  // a released bus clears gate and error and shows the inverse of its last nibble
  task automatic put(input tx1010_sample_t v);
    @(posedge nibble_tx_clock);
    smp <= v.gate ? v : tx1010_sample_t'({2'b00, ~smp.nib});
    repeat (15) @(posedge nibble_tx_clock);
  endtask
endmodule

/* File: test_tx_10_100_line_encoder.sv */
`timescale 1ns/1ns
module test_tx_10_100_line_encoder
  import tx1010_pkg::*;
;
  localparam int IDLE_LINK_PULSE = 200;
  localparam int JAB = 400;
  localparam int UNJ = 300;
  localparam logic [4:0] TBL [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E,
    5'h0F, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic           clk_sys = 1'b0;
  logic           linkClk = 1'b0;
  logic           rst_n = 1'b0;
  logic           speed100 = 1'b1;
  logic [4:0]     strap;
  tx1010_sample_t smp;
  logic           mltPlus, mltMinus, tenLevel, tenDriveEn, jabberStatus;
  logic [15:0]    rnd = 16'hF035;
  logic [4:0]     expQ [$];
  logic [4:0]     lastPush = 5'h00;
  logic [4:0]     sh, seen;
  logic [10:0]    kh;
  logic           pP, pM, s, k, inF;
  int             syn, bc, n, w, mc;
  logic [7:0]     mv, me;
  logic [3:0]     tenExp = 4'h6;
  int             errors = 0;
  int             comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #16 linkClk = ~linkClk;
  end
  tx1010_line_encoder #(.NLP_PERIOD(IDLE_LINK_PULSE), .JABBER_LIM(JAB), .UNJAB_LIM(UNJ)) u_dut (
    .clk_sys, .rst_n, .nibble_tx_clock(linkClk), .transmit_gate(smp.gate),
    .txErr(smp.err), .txNibble(smp.nib), .speed100, .station_address_strap(strap),
    .mltPlus, .mltMinus, .tenLevel, .tenDriveEn, .jabberStatus);
  tx1010_mac_model u_mac (.nibble_tx_clock(linkClk), .smp);
  ////////////////////
  function automatic logic [15:0] lf(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic cmpG(input string nm, input logic [4:0] e, input logic [4:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmpN(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // held nibbles repeat on the line, so runs of one group count once on both sides
  task automatic note(input logic [4:0] g);
    if (g !== lastPush) expQ.push_back(g);
    lastPush = g;
  endtask
  task automatic frame(input int cnt, input logic e);
    logic [3:0] d;
    note(CG_J);
    note(CG_K);
    note(TBL[5]);
    repeat (4) u_mac.put({2'b10, 4'h5});
    for (int i = 0; i < cnt; i++) begin
      rnd = lf(rnd);
      d = rnd[3:0];
      note(e ? CG_HALT : TBL[d]);
      u_mac.put({1'b1, e, d});
    end
    note(CG_T);
    note(CG_R);
    note(CG_IDLE);
    u_mac.put('0);
  endtask
  task automatic drain;
    for (int i = 0; i < 3000 && expQ.size() > 0; i++)
      @(posedge clk_sys);
    if (expQ.size() > 0) begin
      errors++;
      report_and_stop;
    end
  endtask
  task automatic span(input logic lvl, output int c);
    c = 0;
    while ((tenLevel && tenDriveEn) === lvl && c < 1000) begin
      c++;
      @(posedge clk_sys);
    end
    if (c == 1000) begin
      errors++;
      report_and_stop;
    end
  endtask
  ////////////////////
  // line watcher: undo mlt, self-sync the descrambler on idle, then frame on J
  always @(posedge clk_sys) begin
    if (!rst_n || !speed100) begin
      syn = 0;
      inF = 1'b0;
      pP = 1'b0;
      pM = 1'b0;
    end else begin
      s = (mltPlus !== pP) || (mltMinus !== pM);
      pP = mltPlus;
      pM = mltMinus;
      k = (syn < 40) ? !s : kh[10] ^ kh[8];
      syn++;
      kh = {kh[9:0], k};
      sh = {sh[3:0], s ^ k};
      bc++;
      if (!inF && sh === CG_J) begin
        inF = 1'b1;
        bc = 5;
        seen = 5'h00;
      end
      if (inF && bc == 5) begin
        bc = 0;
        if (sh !== seen) begin
          seen = sh;
          cmpG("code group", expQ.size() ? expQ.pop_front() : 5'h00, sh);
          inF = (sh !== CG_IDLE);
        end
      end
    end
  end
  // 10M watcher: first eight half-bits of each frame, bit0 first, a one is low then high
  always @(posedge clk_sys) begin
    if (speed100 || !tenDriveEn) begin
      mc = 0;
    end else if (mc < 8) begin
      mv = {mv[6:0], tenLevel};
      mc++;
      if (mc == 8) begin
        me = {~tenExp[0], tenExp[0], ~tenExp[1], tenExp[1],
              ~tenExp[2], tenExp[2], ~tenExp[3], tenExp[3]};
        cmpN("manchester", {8'h00, me}, {8'h00, mv});
      end
    end
  end
  initial begin
    rnd = lf(rnd);
    strap = rnd[4:0];
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    frame(6, 1'b0);
    frame(3, 1'b1);
    frame(8, 1'b0);
    drain;
    speed100 <= 1'b0;
    span(1'b0, n);
    span(1'b1, n);
    span(1'b0, n);
    span(1'b1, w);
    cmpN("pulse width", 2, w);
    cmpN("pulse period", IDLE_LINK_PULSE, n + w);
    repeat (3) u_mac.put({2'b10, 4'h6});
    cmpN("ten drive on", 1, tenDriveEn);
    u_mac.put('0);
    repeat (20) @(posedge clk_sys);
    cmpN("ten drive off", 0, tenDriveEn);
    tenExp = 4'hA;
    repeat (50) u_mac.put({2'b10, 4'hA});
    cmpN("jabber set", 1, jabberStatus);
    cmpN("jabber drive", 0, tenDriveEn);
    u_mac.put('0);
    repeat (UNJ / 2) @(posedge clk_sys);
    cmpN("jabber held", 1, jabberStatus);
    repeat (UNJ) @(posedge clk_sys);
    cmpN("jabber cleared", 0, jabberStatus);
    tenExp = 4'h3;
    repeat (50) u_mac.put({2'b10, 4'h3});
    u_mac.put('0);
    speed100 <= 1'b1;
    repeat (10) @(posedge clk_sys);
    cmpN("jabber at 100M", 0, jabberStatus);
    repeat (60) @(posedge clk_sys);
    frame(4, 1'b0);
    drain;
    report_and_stop;
  end
endmodule
